// ### design/tcw_prescaler.sv
// Purpose: count-enable pulse generator for the timer
// Assumes: running comes from logic on the same clock
// Notes: divider restarts whenever the timer stops
`timescale 1ns/1ns
module tcw_prescaler
   import tcw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic running,
   input wire logic [2:0] sel,
   // pulse out
   output logic tick
);

   logic [DIV_W-1:0] div_q, div_d;
   logic tick_d;

   // one enable pulse per divided period keeps the whole timer on clk
   always_comb
   begin
      div_d = div_q;
      tick_d = 1'b0;
      if (running)
      begin
         div_d = div_q + 10'h001;
         tick_d = ((div_q & tcw_div_mask(sel)) == tcw_div_mask(sel));
      end
      else
      begin
         div_d = 10'h000;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q <= 10'h000;
         tick <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         tick <= tick_d;
      end
   end

endmodule : tcw_prescaler

// ### design/tcw_timer_ctrl.sv
// Purpose: control registers, count sequence and output routing of a 16-bit timer
// Assumes: byte-wide register port, read data one cycle after the strobe
// Notes: count logic is minimal; it exists to produce update and wraparound events
`timescale 1ns/1ns
module tcw_timer_ctrl
   import tcw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic [DATA_W-1:0] busWdata,
   input wire logic busWr,
   input wire logic busRd,
   output logic [DATA_W-1:0] busRdata,
   // system
   input wire logic standbySleep,
   input wire logic [NCH-1:0] portOut,
   // outputs
   output logic [NCH-1:0] padOut,
   output logic [NCH-1:0] logicBlockOut,
   output logic irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   tcw_bus_req_t req;
   logic [7:0] run_q, run_d;
   logic [7:0] wave_q, wave_d;
   logic [7:0] idle_q, idle_d;
   logic hold_q, hold_d;
   logic [NCH-1:0] fresh_q, fresh_d;
   logic [7:0] imask_q, imask_d;
   logic [7:0] istat_q, istat_d;
   logic [CNT_W-1:0] per_q, per_d;
   logic [NCH-1:0][CNT_W-1:0] cmp_q, cmp_d;
   logic [NCH-1:0][CNT_W-1:0] shd_q, shd_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic down_q, down_d;
   logic [DATA_W-1:0] rdata_d;
   logic [NCH-1:0] pad_d;
   logic irq_d;

   logic running;
   logic tick;
   logic [NCH-1:0] waveLevel;
   tcw_wave_cfg_t cfg;
   logic [2:0] mode;
   logic [CNT_W-1:0] top;
   logic wrapEvt, peakEvt, floorEvt;
   logic updEvt, ovfEvt, forceUpd, copyNow, allFresh;
   logic [NCH-1:0] shdWrite;

   assign req = '{wr: busWr, rd: busRd, addr: busAddr, wdata: busWdata};
   assign mode = wave_q[WAVE_MODE_LSB +: 3];
   assign cfg = '{idle: idle_q[IDLE_LSB +: NCH], pinDrive: wave_q[WAVE_PIN_LSB +: NCH], mode: mode};

   // ----------------------------------------
   // run gating
   // ----------------------------------------
   // standby halts the timer unless told to keep running
   assign running = run_q[RUN_ENABLE_BIT] && (!standbySleep || run_q[RUN_ASLEEP_BIT]);

   tcw_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .running(running),
      .sel(run_q[RUN_SEL_LSB +: 3]),
      .tick(tick)
   );

   tcw_wave_gen u_wave_gen (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(cfg),
      .running(running),
      .tick(tick),
      .cnt(cnt_q),
      .cmp(cmp_q),
      .level(waveLevel)
   );

   // ----------------------------------------
   // count sequence and events
   // ----------------------------------------
   assign top = (mode == WM_FREQ) ? cmp_q[0] : per_q;

   always_comb
   begin
      cnt_d = cnt_q;
      down_d = down_q;
      wrapEvt = 1'b0;
      peakEvt = 1'b0;
      floorEvt = 1'b0;
      if (tick && tcw_is_dual(mode))
      begin
         if (!down_q)
         begin
            if (cnt_q >= top)
            begin
               peakEvt = 1'b1;
               down_d = 1'b1;
               cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
            end
            else
            begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         else if (cnt_q == 16'h0000)
         begin
            floorEvt = 1'b1;
            down_d = 1'b0;
            cnt_d = (top != 16'h0000) ? 16'h0001 : 16'h0000;
         end
         else
         begin
            cnt_d = cnt_q - 16'h0001;
         end
      end
      else if (tick)
      begin
         // single ramps count upward and wrap to bottom at top
         down_d = 1'b0;
         if (cnt_q >= top)
         begin
            wrapEvt = 1'b1;
            cnt_d = 16'h0000;
         end
         else
         begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end

   // update and wraparound placement per wave shape
   always_comb
   begin
      updEvt = 1'b0;
      ovfEvt = 1'b0;
      unique case (mode)
         WM_ONE_RAMP:
         begin
            updEvt = wrapEvt;
            ovfEvt = wrapEvt;
         end
         WM_PEAK:
         begin
            updEvt = floorEvt;
            ovfEvt = peakEvt;
         end
         WM_BOTH:
         begin
            updEvt = floorEvt;
            ovfEvt = peakEvt | floorEvt;
         end
         WM_FLOOR:
         begin
            updEvt = floorEvt;
            ovfEvt = floorEvt;
         end
         default:
         begin
            updEvt = wrapEvt;
            ovfEvt = wrapEvt;
         end
      endcase
   end

   // ----------------------------------------
   // buffered transfer
   // ----------------------------------------
   assign forceUpd = req.wr && (req.addr == OFF_HOLD) && req.wdata[FORCE_UPD_BIT];
   assign copyNow = (updEvt && !hold_q) || forceUpd;
   // channels without pin drive do not hold the transfer back
   assign allFresh = &(fresh_q | ~cfg.pinDrive);

   for (genvar i = 0; i < NCH; i++)
   begin : g_shadow
      assign shdWrite[i] = req.wr && (req.addr[7:1] == (OFF_SHD[7:1] + 7'(i)));
      always_comb
      begin
         shd_d[i] = shd_q[i];
         cmp_d[i] = cmp_q[i];
         if (shdWrite[i] && !req.addr[0])
         begin
            shd_d[i][7:0] = req.wdata;
         end
         if (shdWrite[i] && req.addr[0])
         begin
            shd_d[i][15:8] = req.wdata;
         end
         if (copyNow)
         begin
            cmp_d[i] = shd_q[i];
         end
         // a write in the update cycle still marks the buffer fresh
         fresh_d[i] = shdWrite[i] ? 1'b1 : ((updEvt || forceUpd) ? 1'b0 : fresh_q[i]);
      end
   end

   always_comb
   begin
      hold_d = hold_q;
      if (req.wr && (req.addr == OFF_HOLD))
      begin
         hold_d = req.wdata[HOLD_BIT];
      end
      if (wave_q[WAVE_AUTO_BIT])
      begin
         if (hold_q && allFresh)
         begin
            hold_d = 1'b0;
         end
         else if (!hold_q && copyNow)
         begin
            hold_d = 1'b1;
         end
         else if (!allFresh)
         begin
            hold_d = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb
   begin
      run_d = run_q;
      wave_d = wave_q;
      idle_d = idle_q;
      imask_d = imask_q;
      per_d = per_q;
      if (req.wr)
      begin
         unique case (req.addr)
            OFF_RUN: run_d = req.wdata & RUN_MASK;
            OFF_WAVE: wave_d = req.wdata & WAVE_MASK;
            OFF_IDLE: idle_d = req.wdata & IDLE_MASK;
            OFF_IMASK: imask_d = req.wdata & IRQ_MASK;
            OFF_PER: per_d[7:0] = req.wdata;
            OFF_PER + 8'h01: per_d[15:8] = req.wdata;
            default: ;
         endcase
      end
   end

   // status read clears, but an event in the same cycle survives
   always_comb
   begin
      istat_d = istat_q;
      if (req.rd && (req.addr == OFF_ISTAT))
      begin
         istat_d = 8'h00;
      end
      if (ovfEvt)
      begin
         istat_d[IRQ_WRAP_BIT] = 1'b1;
      end
      if (updEvt || forceUpd)
      begin
         istat_d[IRQ_UPD_BIT] = 1'b1;
      end
      irq_d = |(istat_d & imask_q);
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb
   begin
      rdata_d = 8'h00;
      if (req.rd)
      begin
         unique case (req.addr)
            OFF_RUN: rdata_d = run_q;
            OFF_WAVE: rdata_d = wave_q;
            OFF_IDLE: rdata_d = idle_q;
            OFF_HOLD: rdata_d = {7'h00, hold_q};
            OFF_FRESH: rdata_d = {5'h00, fresh_q};
            OFF_IMASK: rdata_d = imask_q;
            OFF_ISTAT: rdata_d = istat_q;
            OFF_CNT: rdata_d = cnt_q[7:0];
            OFF_CNT + 8'h01: rdata_d = cnt_q[15:8];
            OFF_PER: rdata_d = per_q[7:0];
            OFF_PER + 8'h01: rdata_d = per_q[15:8];
            OFF_CMP: rdata_d = cmp_q[0][7:0];
            OFF_CMP + 8'h01: rdata_d = cmp_q[0][15:8];
            OFF_CMP + 8'h02: rdata_d = cmp_q[1][7:0];
            OFF_CMP + 8'h03: rdata_d = cmp_q[1][15:8];
            OFF_CMP + 8'h04: rdata_d = cmp_q[2][7:0];
            OFF_CMP + 8'h05: rdata_d = cmp_q[2][15:8];
            OFF_SHD: rdata_d = shd_q[0][7:0];
            OFF_SHD + 8'h01: rdata_d = shd_q[0][15:8];
            OFF_SHD + 8'h02: rdata_d = shd_q[1][7:0];
            OFF_SHD + 8'h03: rdata_d = shd_q[1][15:8];
            OFF_SHD + 8'h04: rdata_d = shd_q[2][7:0];
            OFF_SHD + 8'h05: rdata_d = shd_q[2][15:8];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // output routing
   // ----------------------------------------
   // idle levels follow the same pin-drive gate as a running wave
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         pad_d[i] = portOut[i];
         if (cfg.pinDrive[i] && (tcw_makes_wave(mode) || !running))
         begin
            pad_d[i] = waveLevel[i];
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_q <= RST_CTRL;
         wave_q <= RST_CTRL;
         idle_q <= RST_CTRL;
         hold_q <= 1'b0;
         fresh_q <= 3'h0;
         imask_q <= RST_CTRL;
         istat_q <= RST_CTRL;
         per_q <= RST_PER;
         cmp_q <= {NCH{RST_CMP}};
         shd_q <= {NCH{RST_CMP}};
         cnt_q <= 16'h0000;
         down_q <= 1'b0;
         busRdata <= 8'h00;
         padOut <= 3'h0;
         logicBlockOut <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         run_q <= run_d;
         wave_q <= wave_d;
         idle_q <= idle_d;
         hold_q <= hold_d;
         fresh_q <= fresh_d;
         imask_q <= imask_d;
         istat_q <= istat_d;
         per_q <= per_d;
         cmp_q <= cmp_d;
         shd_q <= shd_d;
         cnt_q <= cnt_d;
         down_q <= down_d;
         busRdata <= rdata_d;
         padOut <= pad_d;
         logicBlockOut <= waveLevel;
         irq <= irq_d;
      end
   end

endmodule : tcw_timer_ctrl

// ### design/tcw_wave_gen.sv
// Purpose: per-channel waveform level generator
// Assumes: count and compare values from the same clock
// Notes: level is registered; idle bits win while the timer stops
`timescale 1ns/1ns
module tcw_wave_gen
   import tcw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration and count state
   input wire tcw_wave_cfg_t cfg,
   input wire logic running,
   input wire logic tick,
   input wire logic [CNT_W-1:0] cnt,
   input wire logic [NCH-1:0][CNT_W-1:0] cmp,
   // levels
   output logic [NCH-1:0] level
);

   logic [NCH-1:0] level_d;

   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      always_comb
      begin
         level_d[i] = level[i];
         if (!running)
         begin
            level_d[i] = cfg.idle[i];
         end
         else if (cfg.mode == WM_FREQ)
         begin
            if (tick && (cnt == cmp[i]))
            begin
               level_d[i] = ~level[i];
            end
         end
         else if ((cfg.mode == WM_ONE_RAMP) || tcw_is_dual(cfg.mode))
         begin
            level_d[i] = (cnt < cmp[i]);
         end
         // normal and reserved codes keep the level: no waveform
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level <= 3'h0;
      end
      else
      begin
         level <= level_d;
      end
   end

endmodule : tcw_wave_gen

// ### include/tcw_pkg.sv
// Purpose: shared constants, field layout and carriers of the timer control block
// Assumes: 8-bit register bus, three compare channels, 16-bit count
// Notes: registers are byte wide; 16-bit values take a low and a high byte
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// - keep-running-asleep bit set keeps timer counting in standby; clear halts it there.
// - three-bit prescale code selects divide by 1,2,4,8,16,64,256,1024.
// - enable bit switches whole timer on or off; resets to zero.
// - in frequency and pwm modes a set pin-drive bit routes wave to pin.
// - pin-drive bit clear keeps the wave off the pin; pin shows port value.
// - mode 0 makes no wave; mode 1 tops at compare zero; events at top.
// - mode 3 tops at period; update and wraparound at top.
// - dual-ramp modes top at period, update at bottom, wraparound per code.
// - auto-hold set keeps hold bit high until all enabled compare buffers fresh.
// - after hold clears, next update copies shadows and sets hold again.
// - auto-hold clear leaves the hold bit to software alone.
// - while disabled each idle-level bit drives its channel wave level directly.
// - idle level reaches pad only with pin-drive set; logic block bypasses it.
// - hold bit stops update copies; forced software update still copies.
// - shadow write sets its fresh flag; each update clears it.
package tcw_pkg;

   // ----------------------------------------
   // bus and datapath widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int NCH = 3;
   localparam int DIV_W = 10;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_RUN = 8'h00;
   localparam logic [7:0] OFF_WAVE = 8'h01;
   localparam logic [7:0] OFF_IDLE = 8'h02;
   localparam logic [7:0] OFF_HOLD = 8'h04;
   localparam logic [7:0] OFF_FRESH = 8'h06;
   localparam logic [7:0] OFF_IMASK = 8'h0a;
   localparam logic [7:0] OFF_ISTAT = 8'h0b;
   localparam logic [7:0] OFF_CNT = 8'h20;
   localparam logic [7:0] OFF_PER = 8'h26;
   localparam logic [7:0] OFF_CMP = 8'h28;
   localparam logic [7:0] OFF_SHD = 8'h38;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int RUN_ENABLE_BIT = 0;
   localparam int RUN_SEL_LSB = 1;
   localparam int RUN_ASLEEP_BIT = 7;
   localparam int WAVE_MODE_LSB = 0;
   localparam int WAVE_AUTO_BIT = 3;
   localparam int WAVE_PIN_LSB = 4;
   localparam int IDLE_LSB = 0;
   localparam int HOLD_BIT = 0;
   localparam int FORCE_UPD_BIT = 1;
   localparam int IRQ_WRAP_BIT = 0;
   localparam int IRQ_UPD_BIT = 1;

   localparam logic [7:0] RUN_MASK = 8'h8f;
   localparam logic [7:0] WAVE_MASK = 8'h7f;
   localparam logic [7:0] IDLE_MASK = 8'h07;
   localparam logic [7:0] IRQ_MASK = 8'h03;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_PER = 16'hffff;
   localparam logic [15:0] RST_CMP = 16'h0000;

   // ----------------------------------------
   // wave shape codes
   // ----------------------------------------
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_FREQ = 3'h1;
   localparam logic [2:0] WM_ONE_RAMP = 3'h3;
   localparam logic [2:0] WM_PEAK = 3'h5;
   localparam logic [2:0] WM_BOTH = 3'h6;
   localparam logic [2:0] WM_FLOOR = 3'h7;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [NCH-1:0] idle;
      logic [NCH-1:0] pinDrive;
      logic [2:0] mode;
   } tcw_wave_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tcw_bus_req_t;

   // prescale code to mask of low divider bits that must be all ones
   function automatic logic [DIV_W-1:0] tcw_div_mask(input logic [2:0] sel);
      logic [DIV_W-1:0] m;
      m = 10'h000;
      unique case (sel)
         3'h0: m = 10'h000;
         3'h1: m = 10'h001;
         3'h2: m = 10'h003;
         3'h3: m = 10'h007;
         3'h4: m = 10'h00f;
         3'h5: m = 10'h03f;
         3'h6: m = 10'h0ff;
         3'h7: m = 10'h3ff;
      endcase
      return m;
   endfunction : tcw_div_mask

   // codes that produce a waveform; reserved codes count as normal
   function automatic logic tcw_makes_wave(input logic [2:0] mode);
      return (mode == WM_FREQ) || (mode == WM_ONE_RAMP) || (mode == WM_PEAK) ||
         (mode == WM_BOTH) || (mode == WM_FLOOR);
   endfunction : tcw_makes_wave

   function automatic logic tcw_is_dual(input logic [2:0] mode);
      return (mode == WM_PEAK) || (mode == WM_BOTH) || (mode == WM_FLOOR);
   endfunction : tcw_is_dual

endpackage : tcw_pkg

// ### tb/tb_tcw_timer_ctrl.sv
// Purpose: register-level test of the timer control block
// Assumes: 50 MHz clock, reset low for 12 cycles
// Notes: counter steps are measured over whole divide periods
`timescale 1ns/1ns
module tb_tcw_timer_ctrl
   import tcw_pkg::*;
   ();
   logic clk, rst_n, busWr, busRd, standbySleep, irq;
   logic [ADDR_W-1:0] busAddr;
   logic [DATA_W-1:0] busWdata, busRdata, rdv, c0;
   logic [NCH-1:0] portOut, padOut, logicBlockOut;
   int errorCnt, testsRun, cycCnt;
   int dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
   logic [2:0] modes [8] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   logic [7:0] rbA [4] = '{OFF_RUN, OFF_WAVE, OFF_IDLE, 8'h03};
   logic [7:0] rbE [4] = '{RUN_MASK, WAVE_MASK, IDLE_MASK, 8'h00};
   tcw_timer_ctrl uut (.clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
      .busRd(busRd), .busRdata(busRdata), .standbySleep(standbySleep), .portOut(portOut),
      .padOut(padOut), .logicBlockOut(logicBlockOut), .irq(irq));
   // ----------------------------------------
   // clock, timeout and tasks
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycCnt <= cycCnt + 1;
      if (cycCnt == 80000)
      begin
         errorCnt++;
         stopTest();
      end
   end
   task automatic stopTest();
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stopTest
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      busWr <= 1'b1;
      busAddr <= a;
      busWdata <= d;
      @(posedge clk);
      busWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      busRd <= 1'b1;
      busAddr <= a;
      @(posedge clk);
      busRd <= 1'b0;
      @(negedge clk);
      rdv = busRdata;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(rdv, exp);
   endtask : rdchk
   // two counter reads exactly span cycles apart
   task automatic cntStep(input int span, input logic [7:0] exp);
      rd(OFF_CNT);
      c0 = rdv;
      repeat (span - 2) @(posedge clk);
      rd(OFF_CNT);
      chk(8'(rdv - c0), exp);
   endtask : cntStep
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      busWr = 1'b0;
      busRd = 1'b0;
      busAddr = 8'h00;
      busWdata = 8'h00;
      standbySleep = 1'b0;
      portOut = 3'h5;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
         rdchk(rbA[i], 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(rbA[i], 8'hff);
         rdchk(rbA[i], rbE[i]);
      end
      for (int i = 0; i < 3; i++)
         wr(rbA[i], 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(OFF_RUN, {4'h0, 3'(c), 1'b1});
         cntStep(dv[c] * 37, 8'h25);
      end
      wr(OFF_RUN, 8'h01);
      @(posedge clk) standbySleep <= 1'b1;
      cntStep(37, 8'h00);
      wr(OFF_RUN, 8'h81);
      cntStep(37, 8'h25);
      wr(OFF_RUN, 8'h00);
      @(posedge clk) standbySleep <= 1'b0;
      cntStep(37, 8'h00);
      wr(OFF_PER, 8'h07);
      wr(OFF_PER + 8'h01, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(OFF_RUN, 8'h00);
         wr(OFF_WAVE, {5'h0e, modes[i]});
         rd(OFF_ISTAT);
         wr(OFF_RUN, 8'h01);
         repeat (40) @(posedge clk);
         if (modes[i] != WM_FREQ)
            chk(padOut, (modes[i] inside {3'h0, 3'h2, 3'h4}) ? 3'h5 : 3'h0);
         rdchk(OFF_ISTAT, 8'h03);
      end
      // interrupt: masked, unmasked, then cleared by a status read
      chk(irq, 1'b0);
      wr(OFF_IMASK, 8'h02);
      repeat (20) @(posedge clk);
      chk(irq, 1'b1);
      wr(OFF_RUN, 8'h00);
      rd(OFF_ISTAT);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      wr(OFF_WAVE, 8'h73);
      wr(OFF_HOLD, 8'h01);
      wr(OFF_SHD, 8'h34);
      wr(OFF_SHD + 8'h01, 8'h12);
      rdchk(OFF_FRESH, 8'h01);
      wr(OFF_RUN, 8'h01);
      repeat (40) @(posedge clk);
      rdchk(OFF_CMP, 8'h00);
      rdchk(OFF_FRESH, 8'h00);
      wr(OFF_HOLD, 8'h03);
      rdchk(OFF_CMP, 8'h34);
      rdchk(OFF_CMP + 8'h01, 8'h12);
      rdchk(OFF_HOLD, 8'h01);
      repeat (4) @(posedge clk);
      chk(padOut, 3'h1);
      chk(logicBlockOut, 3'h1);
      // auto hold: an unenabled channel must not release the hold
      wr(OFF_RUN, 8'h00);
      wr(OFF_HOLD, 8'h00);
      wr(OFF_WAVE, 8'h3b);
      wr(OFF_SHD + 8'h04, 8'h05);
      wr(OFF_SHD, 8'h00);
      rdchk(OFF_HOLD, 8'h01);
      wr(OFF_SHD + 8'h02, 8'h05);
      repeat (2) @(posedge clk);
      rdchk(OFF_HOLD, 8'h00);
      wr(OFF_RUN, 8'h01);
      repeat (40) @(posedge clk);
      rdchk(OFF_CMP + 8'h02, 8'h05);
      rdchk(OFF_CMP + 8'h04, 8'h05);
      rdchk(OFF_HOLD, 8'h01);
      chk(padOut[2], 1'b1);
      wr(OFF_RUN, 8'h00);
      wr(OFF_IDLE, 8'h06);
      @(posedge clk) portOut <= 3'h0;
      repeat (4) @(posedge clk);
      chk(logicBlockOut, 3'h6);
      chk(padOut, 3'h2);
      stopTest();
   end
endmodule : tb_tcw_timer_ctrl
bind tcw_timer_ctrl tcw_timer_ctrl_monitor mon (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
   .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .standbySleep(standbySleep),
   .portOut(portOut), .padOut(padOut), .logicBlockOut(logicBlockOut), .irq(irq));

// ### tb/tcw_timer_ctrl_monitor.sv
// Purpose: port-level checks of the timer control block
// Assumes: one clock domain; register shadows rebuilt from bus writes
// Notes: hold bit is only tracked while hardware leaves it alone
`timescale 1ns/1ns
module tcw_timer_ctrl_monitor
   import tcw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic [DATA_W-1:0] busWdata,
   input wire logic busWr,
   input wire logic busRd,
   input wire logic [DATA_W-1:0] busRdata,
   // system and outputs
   input wire logic standbySleep,
   input wire logic [NCH-1:0] portOut,
   input wire logic [NCH-1:0] padOut,
   input wire logic [NCH-1:0] logicBlockOut,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [7:0] runQ, waveQ, idleQ;
   logic holdQ, holdKnownQ;
   logic [1:0] shdChQ;
   logic [2:0] quietQ;
   logic [NCH-1:0] pd;
   assign pd = waveQ[6:4];
   // ----------------------------------------
   // register shadows
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         runQ <= 8'h00;
         waveQ <= 8'h00;
         idleQ <= 8'h00;
         holdQ <= 1'b0;
         holdKnownQ <= 1'b1;
         shdChQ <= 2'h0;
         quietQ <= 3'h0;
      end
      else
      begin
         quietQ <= (quietQ == 3'h7) ? quietQ : quietQ + 3'h1;
         if (busWr && busAddr <= OFF_IDLE)
            quietQ <= 3'h0;
         if (busWr && busAddr == OFF_RUN)
            runQ <= busWdata & RUN_MASK;
         if (busWr && busAddr == OFF_IDLE)
            idleQ <= busWdata & IDLE_MASK;
         if (busWr && busAddr == OFF_WAVE)
            waveQ <= busWdata & WAVE_MASK;
         // hardware owns the hold bit once auto mode was on
         if (busWr && busAddr == OFF_WAVE && busWdata[WAVE_AUTO_BIT])
            holdKnownQ <= 1'b0;
         if (busWr && busAddr == OFF_HOLD && !waveQ[WAVE_AUTO_BIT])
         begin
            holdQ <= busWdata[HOLD_BIT];
            holdKnownQ <= 1'b1;
         end
         if (busWr && busAddr >= OFF_SHD && busAddr <= 8'h3d)
            shdChQ <= 2'((busAddr - OFF_SHD) >> 1);
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_shd_wr;
      busWr && busAddr >= OFF_SHD && busAddr <= 8'h3d && !runQ[RUN_ENABLE_BIT];
   endsequence
   sequence s_fresh_rd;
      !busWr ##1 busRd && busAddr == OFF_FRESH;
   endsequence
   property p_rd_quiet;
      !$past(busRd) |-> busRdata == 8'h00;
   endproperty
   property p_run_rb;
      $past(busRd) && $past(busAddr) == OFF_RUN |-> busRdata == $past(runQ);
   endproperty
   property p_wave_rb;
      $past(busRd) && $past(busAddr) == OFF_WAVE |-> busRdata == $past(waveQ);
   endproperty
   property p_idle_rb;
      $past(busRd) && $past(busAddr) == OFF_IDLE |-> busRdata == $past(idleQ);
   endproperty
   property p_unmapped;
      $past(busRd) && $past(busAddr) == 8'h03 |-> busRdata == 8'h00;
   endproperty
   property p_hold_sw;
      $past(busRd) && $past(busAddr) == OFF_HOLD && $past(holdKnownQ) |-> busRdata == {7'h00, $past(holdQ)};
   endproperty
   property p_fresh_set;
      s_shd_wr ##1 s_fresh_rd |=> busRdata[shdChQ];
   endproperty
   property p_pad_port;
      quietQ >= 3'h3 |-> (padOut & ~pd) == ($past(portOut) & ~pd);
   endproperty
   property p_idle_lb;
      quietQ >= 3'h4 && !runQ[RUN_ENABLE_BIT] |-> logicBlockOut == idleQ[2:0];
   endproperty
   property p_idle_pad;
      quietQ >= 3'h4 && !runQ[RUN_ENABLE_BIT] |-> (padOut & pd) == (idleQ[2:0] & pd);
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside read");
   a_run_rb: assert property (p_run_rb) else $error("run register readback");
   a_wave_rb: assert property (p_wave_rb) else $error("wave register readback");
   a_idle_rb: assert property (p_idle_rb) else $error("idle register readback");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_hold_sw: assert property (p_hold_sw) else $error("hold bit changed by hardware");
   a_fresh_set: assert property (p_fresh_set) else $error("shadow write left fresh clear");
   a_pad_port: assert property (p_pad_port) else $error("undriven pad not port value");
   a_idle_lb: assert property (p_idle_lb) else $error("logic block not idle level");
   a_idle_pad: assert property (p_idle_pad) else $error("driven pad not idle level");
endmodule : tcw_timer_ctrl_monitor
